// ==== dv/jtdr_debugger.sv ====
module jtdr_debugger (
	input wire ref_clk_i,
	input wire tdo_i,
	output logic tms_o,
	output logic tdi_o,
	output logic qen_o
);
	timeunit 1ns;
	timeprecision 1ns;
	integer seed = 32'h95231547;
	int slow = 0;
	initial begin
		tms_o = 1'b1;
		tdi_o = 1'b0;
		qen_o = 1'b0;
	end
	// one qualified cycle per step; pins reach the controller two cycles late
	task automatic step(input logic m, input logic d);
		@(posedge ref_clk_i);
		tms_o <= m;
		tdi_o <= d;
		qen_o <= 1'b1;
		@(posedge ref_clk_i);
		qen_o <= 1'b0;
		repeat (4 + (slow ? $unsigned($random(seed)) % 4 : 0)) @(posedge ref_clk_i);
		tdi_o <= ~d; // a released line must not keep showing the last bit
	endtask
	task automatic shift(input int n, input logic [37:0] din, output logic [37:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			dout[i] = tdo_i;
			step(i == n - 1, din[i]);
		end
	endtask
endmodule

// ==== dv/jtdr_properties.sv ====
module jtdr_properties (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_b_i,
	// debugger pins
	input wire test_clock_qualifier_i,
	input wire serial_test_out_o,
	// pulses and held fields
	input wire restart_o,
	input wire dbgu_write_o,
	input wire dbgu_read_o,
	input wire [4:0] dbgu_addr_o,
	input wire [31:0] dbgu_wdata_o,
	input wire user_update_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	// qualifier low long enough for the two sync stages and the output stage to drain
	sequence qual_idle;
		!test_clock_qualifier_i [*8];
	endsequence
	sequence qual_seen;
		$past(test_clock_qualifier_i, 2) || $past(test_clock_qualifier_i, 3) || $past(test_clock_qualifier_i, 4)
			|| $past(test_clock_qualifier_i, 5) || $past(test_clock_qualifier_i, 6);
	endsequence
	AST_RESTART_CAUSE: assert property (restart_o |-> qual_seen)
		else $error("restart pulse without a qualified cycle");
	AST_RESTART_PULSE: assert property (restart_o |=> !restart_o)
		else $error("restart pulse longer than one cycle");
	AST_WRITE_CAUSE: assert property (dbgu_write_o |-> qual_seen)
		else $error("debug unit write without a qualified cycle");
	AST_READ_CAUSE: assert property (dbgu_read_o |-> qual_seen)
		else $error("debug unit read without a qualified cycle");
	AST_ONE_ACCESS: assert property ((dbgu_write_o || dbgu_read_o) |=> !(dbgu_write_o || dbgu_read_o) [*3])
		else $error("more than one debug unit access per update");
	AST_FIELDS_HOLD: assert property (!dbgu_write_o && !dbgu_read_o |-> $stable(dbgu_addr_o) && $stable(dbgu_wdata_o))
		else $error("debug unit address or data moved without an access");
	AST_IDLE_FREEZE: assert property (qual_idle |-> $stable(serial_test_out_o) && !restart_o && !dbgu_write_o)
		else $error("activity while the qualifier was low");
	AST_USER_CAUSE: assert property (user_update_o |-> qual_seen)
		else $error("user chain update without a qualified cycle");
	AST_RESET_CLEAN: assert property ($rose(rst_b_i) |-> !restart_o && !dbgu_write_o && !serial_test_out_o)
		else $error("outputs not quiet after reset");
endmodule

bind jtdr_top jtdr_properties u_props (.*);

// ==== dv/test_jtag_test_data_registers.sv ====
`include "jtdr_defines.vh"
`define CHK(n, e, a) begin checks_done++; if ((e) !== (a)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module test_jtag_test_data_registers;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID = 32'h2468ace1; // arbitrary value
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic serial_test_in_i, test_mode_select_i, test_clock_qualifier_i, serial_test_out_o;
	logic [31:0] sys_data_in_i = '0, core_data_out_i = '0, core_data_in_o, sys_data_out_o;
	logic external_break_input_i = 1'b0, core_break_o, system_speed_o;
	logic debug_entry_i = 1'b0, entry_watchpoint_i = 1'b0, restart_o;
	logic [4:0] dbgu_addr_o;
	logic [31:0] dbgu_wdata_o, dbgu_rdata_i;
	logic dbgu_write_o, dbgu_read_o, user_scan_out_i = 1'b1;
	logic user_capture_o, user_shift_o, user_update_o;
	logic [37:0] exp_q[$];
	logic [37:0] got_v, ev, av;
	logic got = 1'b0;
	int fail_count = 0;
	int checks_done = 0;
	int reads = 0, caps = 0, shifts = 0, ups = 0;
	jtdr_top #(.ID_VALUE(ID)) uut (.*);
	jtdr_debugger dbg (.ref_clk_i(ref_clk_i), .tdo_i(serial_test_out_o), .tms_o(test_mode_select_i),
		.tdi_o(serial_test_in_i), .qen_o(test_clock_qualifier_i));
	// read data carries its address so a wrong address shows up
	assign dbgu_rdata_i = {dbgu_addr_o, 27'h4d2c1e3};
	initial begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [32:0] rv(input logic [32:0] x);
		return {<<{x}};
	endfunction
	function automatic logic [37:0] rnd();
		logic [63:0] r;
		r = {$random(dbg.seed), $random(dbg.seed)};
		return r[37:0];
	endfunction
	task automatic go(input logic [7:0] seq, input int n);
		for (int i = 0; i < n; i++) dbg.step(seq[i], 1'b0);
	endtask
	task automatic post(input logic [37:0] v);
		got_v <= v;
		got <= 1'b1;
		@(posedge ref_clk_i);
		got <= 1'b0;
	endtask
	task automatic ir(input logic [3:0] c);
		logic [37:0] o;
		exp_q.push_back(38'h1);
		if (c == `JTDR_INS_RESTART) exp_q.push_back(38'h1);
		go(8'b0011, 4);
		dbg.shift(4, {34'h0, c}, o);
		post(o);
		go(8'b01, 2);
	endtask
	// x[38] marks a second result (access or restart) expected after the update
	task automatic dr(input int n, input logic [37:0] din, input logic [37:0] e, input logic [38:0] x);
		logic [37:0] o;
		exp_q.push_back(e);
		if (x[38]) exp_q.push_back(x[37:0]);
		go(8'b001, 3);
		dbg.shift(n, din, o);
		post(o);
		go(8'b01, 2);
	endtask
	always @(posedge ref_clk_i) begin
		reads <= reads + dbgu_read_o;
		caps <= caps + user_capture_o;
		shifts <= shifts + user_shift_o;
		ups <= ups + user_update_o;
		if (got || dbgu_write_o || restart_o) begin
			// nothing due means any result is a mismatch
			if (exp_q.size() == 0) ev = 'x;
			else ev = exp_q.pop_front();
			av = got ? got_v : dbgu_write_o ? {1'b1, dbgu_addr_o, dbgu_wdata_o} : 38'h1;
			`CHK("result", ev, av)
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#3000000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		logic [37:0] din, d2;
		logic [31:0] cd;
		logic [32:0] par;
		logic [3:0] bc [4] = '{`JTDR_INS_BYPASS, `JTDR_INS_RESTART, 4'h0, 4'h9};
		logic [3:0] rs [4] = '{4'h0, 4'h3, 4'h4, 4'h8};
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		sys_data_in_i <= $random(dbg.seed);
		core_data_out_i <= $random(dbg.seed);
		dbg.step(1'b0, 1'b0);
		dr(32, rnd(), {6'h0, ID}, 39'h0);
		`CHK("sys_pass", sys_data_in_i, core_data_in_o)
		`CHK("core_pass", core_data_out_i, sys_data_out_o)
		foreach (bc[i]) begin
			ir(bc[i]);
			dr(2, 38'h3, 38'h2, bc[i] == `JTDR_INS_RESTART ? {1'b1, 38'h1} : 39'h0);
		end
		dbg.slow = 1;
		ir(`JTDR_INS_SCAN_N);
		dr(4, 38'h1, 38'h8, 39'h0);
		ir(`JTDR_INS_INTEST);
		for (int w = 0; w < 3; w++) begin
			cd = $random(dbg.seed);
			din = rnd();
			core_data_out_i <= cd;
			external_break_input_i <= ~w[0];
			entry_watchpoint_i <= w[0];
			debug_entry_i <= (w < 2);
			@(posedge ref_clk_i);
			debug_entry_i <= 1'b0;
			dr(33, din, {5'h0, rv({(w < 2) ? w[0] : external_break_input_i, cd})}, 39'h0);
			par = rv(din[32:0]);
			`CHK("core_in", par[31:0], core_data_in_o)
			`CHK("sys_out", par[31:0], sys_data_out_o)
			`CHK("break", par[32], core_break_o)
			`CHK("speed", par[32], system_speed_o)
		end
		ir(`JTDR_INS_SCAN_N);
		dr(4, 38'h2, 38'h8, 39'h0);
		ir(`JTDR_INS_INTEST);
		din = rnd();
		din[37] = 1'b1;
		dr(38, din, 38'h0, {1'b1, din});
		d2 = rnd();
		d2[37] = 1'b0;
		dr(38, d2, din, 39'h0);
		din = rnd();
		din[37] = 1'b1;
		dr(38, din, {d2[37:32], d2[36:32], 27'h4d2c1e3}, {1'b1, din});
		foreach (rs[i]) begin
			ir(`JTDR_INS_SCAN_N);
			dr(4, {34'h0, rs[i]}, 38'h8, 39'h0);
			ir(`JTDR_INS_INTEST);
			dr(8, 38'hff, (rs[i] == 4'h0) ? 38'hff : 38'h0, 39'h0);
		end
		go(8'h1f, 5);
		dbg.step(1'b0, 1'b0);
		dr(32, rnd(), {6'h0, ID}, 39'h0);
		repeat (10) @(posedge ref_clk_i);
		`CHK("pending", 0, exp_q.size())
		`CHK("reads", 1, reads)
		`CHK("user_caps", 1, caps)
		`CHK("user_shifts", 8, shifts)
		`CHK("user_ups", 1, ups)
		tally_and_finish();
	end
endmodule

// ==== rtl/jtdr_defines.vh ====
`ifndef JTDR_DEFINES_VH
`define JTDR_DEFINES_VH

// instruction codes, 4 bits
`define JTDR_IR_WIDTH 4
`define JTDR_INS_SCAN_N 4'h2
`define JTDR_INS_INTEST 4'hc
`define JTDR_INS_IDCODE 4'he
`define JTDR_INS_BYPASS 4'hf
`define JTDR_INS_RESTART 4'h4
`define JTDR_IR_CAPTURE 4'h1

// chain select register
`define JTDR_SEL_WIDTH 4
`define JTDR_SEL_CAPTURE 4'h8
`define JTDR_SEL_RESET 4'h0
`define JTDR_CHAIN_USER 4'h0
`define JTDR_CHAIN_CORE 4'h1
`define JTDR_CHAIN_DBGU 4'h2

// register widths and field positions
`define JTDR_ID_WIDTH 32
`define JTDR_CORE_WIDTH 33
`define JTDR_CORE_BREAK_BIT 32
`define JTDR_DBGU_WIDTH 38
`define JTDR_DBGU_RW_BIT 37
`define JTDR_DBGU_ADDR_HI 36
`define JTDR_DBGU_ADDR_LO 32
`define JTDR_BYPASS_CAPTURE 1'b0

`endif

// ==== rtl/jtdr_top.v ====
`include "jtdr_defines.vh"

module jtdr_top #(
	parameter [31:0] ID_VALUE = 32'h1234_5671 // arbitrary value
) (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_b_i,
	// debugger pins
	input wire serial_test_in_i,
	input wire test_mode_select_i,
	input wire test_clock_qualifier_i,
	output reg serial_test_out_o,
	// core data scan cells
	input wire [31:0] sys_data_in_i,
	input wire [31:0] core_data_out_i,
	output reg [31:0] core_data_in_o,
	output reg [31:0] sys_data_out_o,
	input wire external_break_input_i,
	output reg core_break_o,
	output reg system_speed_o,
	// debug state
	input wire debug_entry_i,
	input wire entry_watchpoint_i,
	output reg restart_o,
	// debug unit register port
	output reg [4:0] dbgu_addr_o,
	output reg [31:0] dbgu_wdata_o,
	output reg dbgu_write_o,
	output reg dbgu_read_o,
	input wire [31:0] dbgu_rdata_i,
	// user chain 0
	input wire user_scan_out_i,
	output reg user_capture_o,
	output reg user_shift_o,
	output reg user_update_o
);

	localparam [3:0] ST_RESET = 4'h0;
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_SEL_DR = 4'h2;
	localparam [3:0] ST_CAP_DR = 4'h3;
	localparam [3:0] ST_SHIFT_DR = 4'h4;
	localparam [3:0] ST_EXIT1_DR = 4'h5;
	localparam [3:0] ST_PAUSE_DR = 4'h6;
	localparam [3:0] ST_EXIT2_DR = 4'h7;
	localparam [3:0] ST_UPD_DR = 4'h8;
	localparam [3:0] ST_SEL_IR = 4'h9;
	localparam [3:0] ST_CAP_IR = 4'ha;
	localparam [3:0] ST_SHIFT_IR = 4'hb;
	localparam [3:0] ST_EXIT1_IR = 4'hc;
	localparam [3:0] ST_PAUSE_IR = 4'hd;
	localparam [3:0] ST_EXIT2_IR = 4'he;
	localparam [3:0] ST_UPD_IR = 4'hf;

	// pin synchronisers; all three pass the same depth so they stay aligned
	reg tdi_s1_reg, tdi_s2_reg;
	reg tms_s1_reg, tms_s2_reg;
	reg en_s1_reg, en_s2_reg;

	reg [3:0] state_reg, state_next;
	reg [3:0] instr_reg;
	reg [3:0] ir_shift_reg;
	reg [3:0] chain_sel_reg;
	reg [3:0] sel_shift_reg;
	reg bypass_reg;
	reg [31:0] id_shift_reg;
	reg [32:0] core_shift_reg;
	reg [32:0] core_par_reg;
	reg [37:0] dbgu_shift_reg;
	reg dbgu_load_reg;
	reg entry_pending_reg;
	reg entry_cause_reg;

	wire tdi = tdi_s2_reg;
	wire tms = tms_s2_reg;
	wire en = en_s2_reg;

	// instruction decode; anything undefined falls through to bypass
	wire ins_scan_n = (instr_reg == `JTDR_INS_SCAN_N);
	wire ins_intest = (instr_reg == `JTDR_INS_INTEST);
	wire ins_idcode = (instr_reg == `JTDR_INS_IDCODE);
	wire ins_restart = (instr_reg == `JTDR_INS_RESTART);
	wire ins_bypass = !(ins_scan_n || ins_intest || ins_idcode);

	wire sel_user = ins_intest && (chain_sel_reg == `JTDR_CHAIN_USER);
	wire sel_core = ins_intest && (chain_sel_reg == `JTDR_CHAIN_CORE);
	wire sel_dbgu = ins_intest && (chain_sel_reg == `JTDR_CHAIN_DBGU);

	wire cap_dr = en && (state_reg == ST_CAP_DR);
	wire sh_dr = en && (state_reg == ST_SHIFT_DR);
	wire up_dr = en && (state_reg == ST_UPD_DR);
	wire cap_ir = en && (state_reg == ST_CAP_IR);
	wire sh_ir = en && (state_reg == ST_SHIFT_IR);
	wire up_ir = en && (state_reg == ST_UPD_IR);

	// instruction in force after this edge, so a restart loaded on the way into idle counts
	wire [3:0] instr_eff = up_ir ? ir_shift_reg : instr_reg;

	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			tdi_s1_reg <= 1'b0;
			tdi_s2_reg <= 1'b0;
			tms_s1_reg <= 1'b1;
			tms_s2_reg <= 1'b1;
			en_s1_reg <= 1'b0;
			en_s2_reg <= 1'b0;
		end else begin
			tdi_s1_reg <= serial_test_in_i;
			tdi_s2_reg <= tdi_s1_reg;
			tms_s1_reg <= test_mode_select_i;
			tms_s2_reg <= tms_s1_reg;
			en_s1_reg <= test_clock_qualifier_i;
			en_s2_reg <= en_s1_reg;
		end
	end

	// test controller
	always @* begin
		case (state_reg)
		ST_RESET: state_next = tms ? ST_RESET : ST_IDLE;
		ST_IDLE: state_next = tms ? ST_SEL_DR : ST_IDLE;
		ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
		ST_CAP_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
		ST_SHIFT_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
		ST_EXIT1_DR: state_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
		ST_PAUSE_DR: state_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
		ST_EXIT2_DR: state_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
		ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
		ST_SEL_IR: state_next = tms ? ST_RESET : ST_CAP_IR;
		ST_CAP_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
		ST_SHIFT_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
		ST_EXIT1_IR: state_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
		ST_PAUSE_IR: state_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
		ST_EXIT2_IR: state_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
		ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_IDLE;
		default: state_next = ST_RESET;
		endcase
	end

	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_RESET;
		end else if (en) begin
			state_reg <= state_next;
		end
	end

	// instruction register
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ir_shift_reg <= `JTDR_IR_CAPTURE;
			instr_reg <= `JTDR_INS_IDCODE;
		end else begin
			if (cap_ir) begin
				ir_shift_reg <= `JTDR_IR_CAPTURE;
			end else if (sh_ir) begin
				ir_shift_reg <= {tdi, ir_shift_reg[3:1]};
			end
			if (en && state_reg == ST_RESET) begin
				instr_reg <= `JTDR_INS_IDCODE;
			end else if (up_ir) begin
				instr_reg <= ir_shift_reg;
			end
		end
	end

	// chain select register
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			sel_shift_reg <= `JTDR_SEL_CAPTURE;
			chain_sel_reg <= `JTDR_SEL_RESET;
		end else begin
			if (ins_scan_n && cap_dr) begin
				sel_shift_reg <= `JTDR_SEL_CAPTURE;
			end else if (ins_scan_n && sh_dr) begin
				sel_shift_reg <= {tdi, sel_shift_reg[3:1]};
			end
			if (en && state_reg == ST_RESET) begin
				chain_sel_reg <= `JTDR_SEL_RESET;
			end else if (ins_scan_n && up_dr) begin
				chain_sel_reg <= sel_shift_reg;
			end
		end
	end

	// bypass bit and identity register
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			bypass_reg <= `JTDR_BYPASS_CAPTURE;
			id_shift_reg <= 32'h0000_0000;
		end else begin
			if (ins_bypass && cap_dr) begin
				bypass_reg <= `JTDR_BYPASS_CAPTURE;
			end else if (ins_bypass && sh_dr) begin
				bypass_reg <= tdi;
			end
			if (ins_idcode && cap_dr) begin
				id_shift_reg <= ID_VALUE;
			end else if (ins_idcode && sh_dr) begin
				id_shift_reg <= {tdi, id_shift_reg[31:1]};
			end
		end
	end

	// entry cause is held until the core chain is first captured
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			entry_pending_reg <= 1'b0;
			entry_cause_reg <= 1'b0;
		end else if (debug_entry_i) begin
			entry_pending_reg <= 1'b1;
			entry_cause_reg <= entry_watchpoint_i;
		end else if (sel_core && cap_dr) begin
			entry_pending_reg <= 1'b0;
		end
	end

	// core data chain: break cell at bit 32 is the first bit out
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			core_shift_reg <= 33'h0_0000_0000;
			core_par_reg <= 33'h0_0000_0000;
		end else begin
			if (sel_core && cap_dr) begin
				core_shift_reg[31:0] <= core_data_out_i;
				if (entry_pending_reg) begin
					core_shift_reg[`JTDR_CORE_BREAK_BIT] <= entry_cause_reg;
				end else begin
					core_shift_reg[`JTDR_CORE_BREAK_BIT] <= external_break_input_i;
				end
			end else if (sel_core && sh_dr) begin
				core_shift_reg <= {core_shift_reg[31:0], tdi};
			end
			if (sel_core && up_dr) begin
				core_par_reg <= core_shift_reg;
			end
		end
	end

	// debug unit chain: no capture; read data lands one cycle after the update
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			dbgu_shift_reg <= 38'h00_0000_0000;
			dbgu_load_reg <= 1'b0;
		end else begin
			dbgu_load_reg <= sel_dbgu && up_dr && !dbgu_shift_reg[`JTDR_DBGU_RW_BIT];
			if (dbgu_load_reg) begin
				dbgu_shift_reg[31:0] <= dbgu_rdata_i;
			end else if (sel_dbgu && sh_dr) begin
				dbgu_shift_reg <= {tdi, dbgu_shift_reg[37:1]};
			end
		end
	end

	// serial path pick; a combinational choice keeps the output stage a single flop
	reg serial_out_next;
	always @* begin
		serial_out_next = 1'b0;
		if (state_reg == ST_SHIFT_IR) begin
			serial_out_next = ir_shift_reg[0];
		end else if (ins_scan_n) begin
			serial_out_next = sel_shift_reg[0];
		end else if (ins_idcode) begin
			serial_out_next = id_shift_reg[0];
		end else if (ins_bypass) begin
			serial_out_next = bypass_reg;
		end else if (sel_core) begin
			serial_out_next = core_shift_reg[`JTDR_CORE_BREAK_BIT];
		end else if (sel_dbgu) begin
			serial_out_next = dbgu_shift_reg[0];
		end else if (sel_user) begin
			// chain 0 lives outside this block; its serial bit is passed through as is
			serial_out_next = user_scan_out_i;
		end
	end

	// one scan cell per data bit: test mode swaps the pass-through for the chain
	wire [31:0] cell_to_core;
	wire [31:0] cell_to_sys;
	genvar bit_idx;
	generate
		for (bit_idx = 0; bit_idx < 32; bit_idx = bit_idx + 1) begin : g_cell
			assign cell_to_core[bit_idx] = sel_core ? core_par_reg[bit_idx] : sys_data_in_i[bit_idx];
			assign cell_to_sys[bit_idx] = sel_core ? core_shift_reg[bit_idx] : core_data_out_i[bit_idx];
		end
	endgenerate

	// serial output stage
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			serial_test_out_o <= 1'b0;
		end else begin
			serial_test_out_o <= serial_out_next;
		end
	end

	// cell outputs, registered; the muxes cost one cycle of latency
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			core_data_in_o <= 32'h0000_0000;
			sys_data_out_o <= 32'h0000_0000;
			core_break_o <= 1'b0;
			system_speed_o <= 1'b0;
		end else begin
			// cells drive the core and system only in test mode, except system_speed_o, which always follows the break cell of core_par_reg
			core_data_in_o <= cell_to_core;
			sys_data_out_o <= cell_to_sys;
			core_break_o <= sel_core ? core_par_reg[`JTDR_CORE_BREAK_BIT] : external_break_input_i;
			system_speed_o <= core_par_reg[`JTDR_CORE_BREAK_BIT];
		end
	end

	// restart pulse; it looks at the instruction in force after this edge
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			restart_o <= 1'b0;
		end else begin
			restart_o <= en && (state_next == ST_IDLE) && (state_reg != ST_IDLE)
				&& (instr_eff == `JTDR_INS_RESTART);
		end
	end

	// debug unit and user chain strobes
	// address and data hold from the last access, so the debug unit may sample them late
	always @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			dbgu_addr_o <= 5'h00;
			dbgu_wdata_o <= 32'h0000_0000;
			dbgu_write_o <= 1'b0;
			dbgu_read_o <= 1'b0;
			user_capture_o <= 1'b0;
			user_shift_o <= 1'b0;
			user_update_o <= 1'b0;
		end else begin
			if (sel_dbgu && up_dr) begin
				dbgu_addr_o <= dbgu_shift_reg[`JTDR_DBGU_ADDR_HI:`JTDR_DBGU_ADDR_LO];
				dbgu_wdata_o <= dbgu_shift_reg[31:0];
			end
			dbgu_write_o <= sel_dbgu && up_dr && dbgu_shift_reg[`JTDR_DBGU_RW_BIT];
			dbgu_read_o <= sel_dbgu && up_dr && !dbgu_shift_reg[`JTDR_DBGU_RW_BIT];
			user_capture_o <= sel_user && cap_dr;
			user_shift_o <= sel_user && sh_dr;
			user_update_o <= sel_user && up_dr;
		end
	end

endmodule
